// ==== design/charge_pkg.sv ====
// Package with constants, modes, states and carrier structs for the charge sequencer.
`default_nettype none
package charge_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned SW_FREQ_HZ = 3_000_000;
   localparam int unsigned SW_PERIOD_CYC = CLK_HZ / SW_FREQ_HZ;
   localparam int unsigned DUTY_MAX_PERMILLE = 995;
   localparam int unsigned DUTY_W = 10;
   localparam int unsigned PREVIEW_US = 128;
   localparam int unsigned PULSE_CYC = PREVIEW_US * (CLK_HZ / 1_000_000);
   localparam int unsigned TICK_HZ = 1000;
   localparam int unsigned TICK_CYC = CLK_HZ / TICK_HZ;
   localparam int unsigned LONG_MIN = 32;
   localparam int unsigned LONG_TICKS = LONG_MIN * 60 * TICK_HZ;
   localparam int unsigned SHORT_SEC = 32;
   localparam int unsigned SHORT_TICKS = SHORT_SEC * TICK_HZ;
   localparam int unsigned TMR_W = 24;
   localparam int unsigned CUR_W = 8;
   localparam int unsigned VREG_W = 6;
   localparam logic [CUR_W-1:0] INPUT_CURRENT_LIMIT_DEFAULT = 8'h01;
   localparam logic [CUR_W-1:0] ICHG_DEFAULT = 8'h00;
   localparam logic [CUR_W-1:0] TERMINATION_CURRENT_DEFAULT = 8'h01;
   localparam logic [VREG_W-1:0] VREG_DEFAULT = 6'h02;
   localparam logic [VREG_W-1:0] VREG_MAX = 6'h2F;
   localparam logic [CUR_W-1:0] RAMP_STEP = 8'h01;
   localparam logic [1:0] STAT_READY = 2'h0;
   localparam logic [1:0] STAT_CHARGING = 2'h1;
   localparam logic [1:0] STAT_DONE = 2'h2;
   localparam logic [1:0] STAT_FAULT = 2'h3;

   typedef enum logic [1:0] {
      MODE_CHARGE = 2'h0,
      MODE_BOOST = 2'h1,
      MODE_HIGH_Z = 2'h3
   } op_mode_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_SHORT = 3'h1,
      ST_FAST = 3'h3,
      ST_VREG = 3'h2,
      ST_DONE = 3'h6,
      ST_FAULT = 3'h7
   } chg_state_t;

   typedef struct packed {
      logic [CUR_W-1:0] input_current_limit;
      logic [CUR_W-1:0] fast_charge_current;
      logic [CUR_W-1:0] termination_current;
      logic [VREG_W-1:0] regulation_voltage;
      logic term_enable;
      logic charge_enable;
   } charge_params_t;

   typedef struct packed {
      logic below_short;
      logic below_recharge;
      logic near_regulation;
      logic at_termination;
      logic weak_battery;
      logic high_side_at_limit;
      logic low_side_above_sync;
      logic thermal_shutdown;
   } sense_t;
endpackage
`default_nettype wire

// ==== design/charge_sequencer.sv ====
// Charge sequencer with mode select, PWM control and two stage safety timer.
`default_nettype none
//
// Overview of operation
// - Three modes: charge, boost, high impedance standby with neither active.
// - PWM runs at fixed 3 MHz, duty from zero to 99.5 percent.
// - High-side switch current at peak limit ends the high-side on time for the rest of the PWM period.
// - Low-side switch conducts only while its current exceeds sync threshold.
// - Below short threshold at precharge, supply only small short-circuit current.
// - Between short threshold and regulation, ramp current toward programmed level.
// - Input current limit defaults after reset; host may reprogram it and charge current.
// - Regulation voltage is host programmable within range, using sensed pack voltage.
// - In regulation, end charge at termination current above recharge threshold.
// - Termination is suppressed while host clears the termination enable bit.
// - New cycle on recharge drop, enable toggle, reset bit; weak battery at power-on never starts one, sense is still zero then.
// - Charging starts long timer; any host write stops it.
// - Stopping the long timer by host write starts the short timer.
// - Writing kick bit restarts short timer; device clears the bit itself.
// - Short timer expiry ends charge, restores defaults, restarts long timer, resumes.
// - Long timer expiry turns charger off and reports fault code.
// - Fault clears only at power-on; status changes only after host reads it, except the fault code, shown at once.
// - Every fault gives one 128 us low pulse on open-drain indicator.
// - Thermal shutdown stops switching and freezes all safety timers.
module charge_sequencer (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic host_write_in,
   input wire charge_pkg::charge_params_t host_params_in,
   input wire logic safety_timer_kick_in,
   input wire logic host_reset_bit_in,
   input wire logic status_read_in,
   input wire charge_pkg::op_mode_t mode_request_in,
   input wire logic [charge_pkg::DUTY_W-1:0] duty_request_in,
   input wire charge_pkg::sense_t sense_in,
   output charge_pkg::op_mode_t op_mode_out,
   output charge_pkg::charge_params_t active_params_out,
   output logic [charge_pkg::CUR_W-1:0] current_target_out,
   output logic short_current_on_out,
   output logic high_side_switch_out,
   output logic low_side_switch_out,
   output logic input_blocking_switch_out,
   output logic safety_timer_kick_out,
   output logic [1:0] charge_state_code_out,
   output logic short_timer_mode_out,
   output logic stat_pin_out,
   output logic stat_pin_oe_out
);
   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   localparam int unsigned SN = $bits(charge_pkg::sense_t);
   logic [SN-1:0] s1_reg, s2_reg, s3_reg, sense_reg;
   logic [SN-1:0] sense_next;
   charge_pkg::sense_t sense;
   always_comb begin
      sense_next = sense_reg;
      for (int i = 0; i < SN; i++) begin
         if (s2_reg[i] == s3_reg[i]) begin
            sense_next[i] = s3_reg[i];
         end
      end
   end
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         sense_reg <= '0;
      end else begin
         s1_reg <= sense_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         sense_reg <= sense_next;
      end
   end
   assign sense = charge_pkg::sense_t'(sense_reg);
   // ------------------------------------------------------------
   // Tick prescaler and safety timers
   // ------------------------------------------------------------
   logic [16:0] presc_reg, presc_next;
   logic tick;
   logic long_load, short_load, long_exp, short_exp;
   logic long_run_reg, long_run_next, short_run_reg, short_run_next;
   logic frozen;
   assign frozen = sense.thermal_shutdown;
   assign tick = (presc_reg == 17'(charge_pkg::TICK_CYC - 1));
   always_comb begin
      presc_next = presc_reg;
      if (!frozen) begin
         presc_next = tick ? '0 : presc_reg + 17'h00001;
      end
   end
   safety_timer long_timer (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .tick_in(tick),
      .load_in(long_load),
      .run_in(long_run_reg && !frozen),
      .load_value_in(charge_pkg::TMR_W'(charge_pkg::LONG_TICKS)),
      .expired_out(long_exp)
   );
   safety_timer short_timer (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .tick_in(tick),
      .load_in(short_load),
      .run_in(short_run_reg && !frozen),
      .load_value_in(charge_pkg::TMR_W'(charge_pkg::SHORT_TICKS)),
      .expired_out(short_exp)
   );

   // ------------------------------------------------------------
   // Charge state machine
   // ------------------------------------------------------------
   charge_pkg::chg_state_t state_reg, state_next;
   charge_pkg::charge_params_t par_reg, par_next;
   charge_pkg::charge_params_t defaults;
   logic [charge_pkg::CUR_W-1:0] ramp_reg, ramp_next;
   logic [1:0] code_reg, code_next;
   logic code_read_reg, code_read_next, kick_reg, kick_next;
   logic ce_prev_reg, ce_prev_next, por_reg, por_next;
   logic fault_evt, start_cycle, charging;
   logic [charge_pkg::CUR_W-1:0] limit;
   logic [1:0] code_want;
   assign defaults = charge_pkg::charge_params_t'({charge_pkg::INPUT_CURRENT_LIMIT_DEFAULT,
      charge_pkg::ICHG_DEFAULT, charge_pkg::TERMINATION_CURRENT_DEFAULT, charge_pkg::VREG_DEFAULT,
      1'b0, 1'b1});
   assign limit = (par_reg.fast_charge_current < par_reg.input_current_limit) ?
      par_reg.fast_charge_current : par_reg.input_current_limit;
   assign charging = (state_reg == charge_pkg::ST_SHORT) || (state_reg == charge_pkg::ST_FAST)
      || (state_reg == charge_pkg::ST_VREG);
   assign start_cycle = (ce_prev_reg != par_reg.charge_enable)
      || host_reset_bit_in
      || (por_reg && sense.weak_battery)
      || (state_reg == charge_pkg::ST_DONE && sense.below_recharge);
   always_comb begin
      state_next = state_reg;
      par_next = par_reg;
      ramp_next = ramp_reg;
      long_load = 1'b0;
      short_load = 1'b0;
      long_run_next = long_run_reg;
      short_run_next = short_run_reg;
      kick_next = 1'b0;
      fault_evt = 1'b0;
      ce_prev_next = par_reg.charge_enable;
      por_next = 1'b0;
      code_want = charge_pkg::STAT_READY;
      if (host_write_in && state_reg != charge_pkg::ST_FAULT) begin
         par_next = host_params_in;
         if (host_params_in.regulation_voltage > charge_pkg::VREG_MAX) begin
            par_next.regulation_voltage = charge_pkg::VREG_MAX;
         end
         if (long_run_reg) begin
            long_run_next = 1'b0;
            short_run_next = 1'b1;
            short_load = 1'b1;
         end
         if (safety_timer_kick_in) begin
            long_run_next = 1'b0;
            short_run_next = 1'b1;
            short_load = 1'b1;
            kick_next = 1'b1;
         end
      end
      unique case (state_reg)
         charge_pkg::ST_IDLE, charge_pkg::ST_DONE: begin
            code_want = (state_reg == charge_pkg::ST_DONE) ? charge_pkg::STAT_DONE :
               charge_pkg::STAT_READY;
            if (start_cycle && par_next.charge_enable && mode_request_in == charge_pkg::MODE_CHARGE) begin
               state_next = charge_pkg::ST_SHORT;
               ramp_next = '0;
               long_load = 1'b1;
               long_run_next = 1'b1;
               short_run_next = 1'b0;
            end
         end
         charge_pkg::ST_SHORT, charge_pkg::ST_FAST, charge_pkg::ST_VREG: begin
            code_want = charge_pkg::STAT_CHARGING;
            if (state_reg == charge_pkg::ST_SHORT && !sense.below_short) begin
               state_next = charge_pkg::ST_FAST;
            end else if (state_reg == charge_pkg::ST_FAST && sense.near_regulation) begin
               state_next = charge_pkg::ST_VREG;
            end
            if (state_reg != charge_pkg::ST_SHORT && !frozen) begin
               if (ramp_reg < limit) begin
                  ramp_next = ramp_reg + charge_pkg::RAMP_STEP;
               end else begin
                  ramp_next = limit;
               end
            end
            if (state_reg == charge_pkg::ST_VREG && sense.at_termination
               && !sense.below_recharge && par_reg.term_enable) begin
               state_next = charge_pkg::ST_DONE;
               long_run_next = 1'b0;
               short_run_next = 1'b0;
            end
            if (!par_next.charge_enable || mode_request_in != charge_pkg::MODE_CHARGE) begin
               state_next = charge_pkg::ST_IDLE;
            end
            if (short_exp) begin
               par_next = defaults;
               state_next = charge_pkg::ST_SHORT;
               ramp_next = '0;
               short_run_next = 1'b0;
               long_load = 1'b1;
               long_run_next = 1'b1;
            end
            if (long_exp) begin
               state_next = charge_pkg::ST_FAULT;
               fault_evt = 1'b1;
               long_run_next = 1'b0;
               short_run_next = 1'b0;
            end
         end
         charge_pkg::ST_FAULT: begin
            code_want = charge_pkg::STAT_FAULT;
         end
      endcase
      code_next = code_reg;
      code_read_next = code_read_reg || status_read_in;
      if (code_want != code_reg && (code_read_reg || status_read_in)) begin
         code_next = code_want;
         code_read_next = 1'b0;
      end
      if (state_next == charge_pkg::ST_FAULT) begin
         code_next = charge_pkg::STAT_FAULT;
      end
   end
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         presc_reg <= '0;
         state_reg <= charge_pkg::ST_IDLE;
         par_reg <= defaults;
         ramp_reg <= '0;
         long_run_reg <= 1'b0;
         short_run_reg <= 1'b0;
         kick_reg <= 1'b0;
         code_reg <= charge_pkg::STAT_READY;
         code_read_reg <= 1'b1;
         ce_prev_reg <= 1'b1;
         por_reg <= 1'b1;
      end else begin
         presc_reg <= presc_next;
         state_reg <= state_next;
         par_reg <= par_next;
         ramp_reg <= ramp_next;
         long_run_reg <= long_run_next;
         short_run_reg <= short_run_next;
         kick_reg <= kick_next;
         code_reg <= code_next;
         code_read_reg <= code_read_next;
         ce_prev_reg <= ce_prev_next;
         por_reg <= por_next;
      end
   end
   // ------------------------------------------------------------
   // PWM and switch drive
   // ------------------------------------------------------------
   // The period is an integer number of core cycles, so the rate is 100/33 MHz.
   logic [5:0] pwm_cnt_reg, pwm_cnt_next;
   logic cut_reg, cut_next;
   localparam int unsigned DUTYW_L = 16;
   logic [DUTYW_L-1:0] on_cyc;
   logic [charge_pkg::DUTY_W-1:0] duty;
   logic hs_reg, hs_next, ls_reg, ls_next, pwm_on;
   assign duty = (duty_request_in > charge_pkg::DUTY_W'(charge_pkg::DUTY_MAX_PERMILLE)) ?
      charge_pkg::DUTY_W'(charge_pkg::DUTY_MAX_PERMILLE) : duty_request_in;
   assign on_cyc = DUTYW_L'((32'(duty) * charge_pkg::SW_PERIOD_CYC) / 1000);
   assign pwm_on = (state_reg == charge_pkg::ST_FAST || state_reg == charge_pkg::ST_VREG)
      && !frozen && op_mode_out == charge_pkg::MODE_CHARGE;
   always_comb begin
      pwm_cnt_next = (pwm_cnt_reg == 6'(charge_pkg::SW_PERIOD_CYC - 1)) ? 6'h00 :
         pwm_cnt_reg + 6'h01;
      cut_next = cut_reg;
      if (pwm_cnt_next == 6'h00) begin
         cut_next = 1'b0;
      end else if (sense.high_side_at_limit) begin
         cut_next = 1'b1;
      end
      hs_next = pwm_on && !cut_next && (DUTYW_L'(pwm_cnt_next) < on_cyc);
      ls_next = pwm_on && !hs_next && sense.low_side_above_sync;
   end
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         pwm_cnt_reg <= '0;
         cut_reg <= 1'b0;
         hs_reg <= 1'b0;
         ls_reg <= 1'b0;
      end else begin
         pwm_cnt_reg <= pwm_cnt_next;
         cut_reg <= cut_next;
         hs_reg <= hs_next;
         ls_reg <= ls_next;
      end
   end
   // ------------------------------------------------------------
   // Fault pulse on the open-drain indicator
   // ------------------------------------------------------------
   logic [14:0] pulse_reg, pulse_next;
   always_comb begin
      pulse_next = (pulse_reg != '0) ? pulse_reg - 15'h0001 : '0;
      if (fault_evt) begin
         pulse_next = 15'(charge_pkg::PULSE_CYC);
      end
   end
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         pulse_reg <= '0;
      end else begin
         pulse_reg <= pulse_next;
      end
   end
   // High impedance mode turns off both switch paths and the input switch.
   assign op_mode_out = (mode_request_in == charge_pkg::MODE_BOOST) ? charge_pkg::MODE_BOOST :
      (mode_request_in == charge_pkg::MODE_HIGH_Z) ? charge_pkg::MODE_HIGH_Z :
      charge_pkg::MODE_CHARGE;
   assign active_params_out = par_reg;
   assign current_target_out = ramp_reg;
   assign short_current_on_out = (state_reg == charge_pkg::ST_SHORT) && !frozen;
   assign high_side_switch_out = hs_reg;
   assign low_side_switch_out = ls_reg;
   assign input_blocking_switch_out = charging && !frozen;
   assign safety_timer_kick_out = kick_reg;
   assign charge_state_code_out = code_reg;
   assign short_timer_mode_out = short_run_reg;
   assign stat_pin_out = 1'b0;
   assign stat_pin_oe_out = (pulse_reg != '0);
endmodule
`default_nettype wire

// ==== design/safety_timer.sv ====
// Prescaled down counter used for both safety timer stages.
`default_nettype none
module safety_timer (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic tick_in,
   input wire logic load_in,
   input wire logic run_in,
   input wire logic [charge_pkg::TMR_W-1:0] load_value_in,
   output logic expired_out
);
   logic [charge_pkg::TMR_W-1:0] count_reg;
   logic [charge_pkg::TMR_W-1:0] count_next;
   logic expired_reg;
   logic expired_next;

   always_comb begin
      count_next = count_reg;
      expired_next = 1'b0;
      if (load_in) begin
         count_next = load_value_in;
      end else if (run_in && tick_in && count_reg != '0) begin
         count_next = count_reg - 1'b1;
         expired_next = (count_reg == {{(charge_pkg::TMR_W-1){1'b0}}, 1'b1});
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         count_reg <= '0;
         expired_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         expired_reg <= expired_next;
      end
   end

   assign expired_out = expired_reg;
endmodule
`default_nettype wire

// ==== testbench/charge_sequencer_monitor.sv ====
// Checker for the charge sequencer, bound to its ports.
`default_nettype none
module charge_sequencer_checker (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic host_write_in,
   input wire charge_pkg::charge_params_t host_params_in,
   input wire logic safety_timer_kick_in,
   input wire logic status_read_in,
   input wire charge_pkg::sense_t sense_in,
   input wire charge_pkg::charge_params_t active_params_out,
   input wire logic high_side_switch_out,
   input wire logic low_side_switch_out,
   input wire logic safety_timer_kick_out,
   input wire logic [1:0] charge_state_code_out,
   input wire logic short_timer_mode_out,
   input wire logic stat_pin_out,
   input wire logic stat_pin_oe_out
);
   // ------------------------------------------------------------
   // Status read tracking
   // ------------------------------------------------------------
   logic [1:0] code_prev_reg;
   logic read_seen_reg;
   logic read_seen_next;
   always_comb begin
      read_seen_next = read_seen_reg | status_read_in;
      if (charge_state_code_out != code_prev_reg) begin
         read_seen_next = status_read_in;
      end
      if (rst_in) begin
         read_seen_next = 1'b0;
      end
   end
   always_ff @(posedge core_clk_in) begin
      read_seen_reg <= read_seen_next;
      code_prev_reg <= charge_state_code_out;
   end
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   sequence s_kick_write;
      host_write_in && safety_timer_kick_in && charge_state_code_out != charge_pkg::STAT_FAULT;
   endsequence
   property p_kick_pulse;
      s_kick_write |=> safety_timer_kick_out && short_timer_mode_out;
   endproperty
   a_kick_pulse: assert property (p_kick_pulse) else $error("kick write gave no pulse");
   property p_kick_cause;
      safety_timer_kick_out |-> $past(host_write_in && safety_timer_kick_in);
   endproperty
   a_kick_cause: assert property (p_kick_cause) else $error("kick pulse without cause");
   property p_params_load;
      host_write_in && charge_state_code_out != charge_pkg::STAT_FAULT |=>
         active_params_out.fast_charge_current == $past(host_params_in.fast_charge_current)
         && active_params_out.term_enable == $past(host_params_in.term_enable);
   endproperty
   a_params_load: assert property (p_params_load) else $error("write not loaded");
   property p_reset_defaults;
      disable iff (1'b0) rst_in |=> charge_state_code_out == charge_pkg::STAT_READY
         && active_params_out.input_current_limit == charge_pkg::INPUT_CURRENT_LIMIT_DEFAULT;
   endproperty
   a_reset_defaults: assert property (p_reset_defaults) else $error("bad reset state");
   property p_fault_sticky;
      charge_state_code_out == charge_pkg::STAT_FAULT |=> charge_state_code_out == 2'h3;
   endproperty
   a_fault_sticky: assert property (p_fault_sticky) else $error("fault left");
   property p_status_hold;
      charge_state_code_out != code_prev_reg && charge_state_code_out != 2'h3 |-> read_seen_reg;
   endproperty
   a_status_hold: assert property (p_status_hold) else $error("code changed unread");
   property p_term_off;
      !active_params_out.term_enable && charge_state_code_out == charge_pkg::STAT_CHARGING
         |=> charge_state_code_out != charge_pkg::STAT_DONE;
   endproperty
   a_term_off: assert property (p_term_off) else $error("termination not suppressed");
   property p_thermal_stop;
      sense_in.thermal_shutdown [*8] |-> !high_side_switch_out && !low_side_switch_out;
   endproperty
   a_thermal_stop: assert property (p_thermal_stop) else $error("switching in shutdown");
   property p_fault_pulse;
      $rose(stat_pin_oe_out) |-> !stat_pin_out && charge_state_code_out == 2'h3
         ##1 stat_pin_oe_out [*8];
   endproperty
   a_fault_pulse: assert property (p_fault_pulse) else $error("bad fault pulse");
endmodule
bind charge_sequencer charge_sequencer_checker charge_sequencer_checker_inst (.core_clk_in,
   .rst_in, .host_write_in, .host_params_in, .safety_timer_kick_in, .status_read_in,
   .sense_in, .active_params_out, .high_side_switch_out, .low_side_switch_out,
   .safety_timer_kick_out, .charge_state_code_out, .short_timer_mode_out, .stat_pin_out,
   .stat_pin_oe_out);
`default_nettype wire

// ==== testbench/host_model.sv ====
// Host processor model issuing control writes, kicks and status reads.
`default_nettype none
module host_model (
   input wire logic core_clk_in,
   output logic host_write_out,
   output charge_pkg::charge_params_t host_params_out,
   output logic kick_out,
   output logic reset_bit_out,
   output logic status_read_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      host_write_out = 1'b0;
      host_params_out = '0;
      kick_out = 1'b0;
      reset_bit_out = 1'b0;
      status_read_out = 1'b0;
   end
   // Released data is inverted so that stale values never look valid.
   task automatic write_params(input charge_pkg::charge_params_t p, input logic kick);
      @(posedge core_clk_in);
      host_write_out <= 1'b1;
      host_params_out <= p;
      kick_out <= kick;
      @(posedge core_clk_in);
      host_write_out <= 1'b0;
      host_params_out <= ~p;
      kick_out <= ~kick;
   endtask
   task automatic read_status();
      @(posedge core_clk_in);
      status_read_out <= 1'b1;
      @(posedge core_clk_in);
      status_read_out <= 1'b0;
   endtask
   task automatic set_reset_bit();
      @(posedge core_clk_in);
      reset_bit_out <= 1'b1;
      @(posedge core_clk_in);
      reset_bit_out <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== testbench/test_charge_sequencer.sv ====
// Self-checking bench for the charge sequencer.
`default_nettype none
module test_charge_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic host_write_in, kick_in, reset_bit_in, status_read_in;
   charge_pkg::charge_params_t host_params_in, active_params_out, p;
   charge_pkg::op_mode_t mode_request_in = charge_pkg::MODE_CHARGE;
   charge_pkg::op_mode_t op_mode_out;
   charge_pkg::op_mode_t modes [3] = '{charge_pkg::MODE_CHARGE, charge_pkg::MODE_BOOST,
      charge_pkg::MODE_HIGH_Z};
   logic [charge_pkg::DUTY_W-1:0] duty_request_in = 10'h000;
   charge_pkg::sense_t sense_in = '0;
   logic [charge_pkg::CUR_W-1:0] current_target_out;
   logic short_on, hs, ls, ibs, kick_out, stm, stat, stat_oe;
   logic [1:0] code;
   logic [7:0] hi, lo, hi_mid;
   int num_errors = 0;
   int compares = 0;
   always #5 core_clk_in = ~core_clk_in;
   host_model host_model_inst (.core_clk_in, .host_write_out(host_write_in),
      .host_params_out(host_params_in), .kick_out(kick_in), .reset_bit_out(reset_bit_in),
      .status_read_out(status_read_in));
   charge_sequencer charge_sequencer_inst (.core_clk_in, .rst_in, .host_write_in,
      .host_params_in, .safety_timer_kick_in(kick_in), .host_reset_bit_in(reset_bit_in),
      .status_read_in, .mode_request_in, .duty_request_in, .sense_in, .op_mode_out,
      .active_params_out, .current_target_out,
      .short_current_on_out(short_on), .high_side_switch_out(hs), .low_side_switch_out(ls),
      .input_blocking_switch_out(ibs), .safety_timer_kick_out(kick_out),
      .charge_state_code_out(code), .short_timer_mode_out(stm), .stat_pin_out(stat),
      .stat_pin_oe_out(stat_oe));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask
   // Bounded wait; a wait that runs out ends the run at once.
   task automatic wait_code(input logic [1:0] exp);
      int n;
      n = 0;
      while (code !== exp && n < 60) begin
         @(posedge core_clk_in);
         #1;
         n++;
      end
      check("state code", {30'h0, exp}, {30'h0, code});
      if (n == 60) end_of_test();
   endtask
   // Counts switch-on cycles over two PWM periods.
   task automatic pwm_count();
      hi = 8'h00;
      lo = 8'h00;
      repeat (10) @(posedge core_clk_in);
      repeat (66) begin
         @(posedge core_clk_in);
         #1;
         hi += {7'h00, hs};
         lo += {7'h00, ls};
      end
   endtask
   initial begin
      repeat (4) @(posedge core_clk_in);
      rst_in <= 1'b0;
      @(posedge core_clk_in);
      #1;
      check("params", {charge_pkg::INPUT_CURRENT_LIMIT_DEFAULT, 8'h00, 8'h01, 6'h02, 2'b01},
         active_params_out);
      check("status", 32'h0, {29'h0, code, stat_oe});
      foreach (modes[i]) begin
         @(posedge core_clk_in);
         mode_request_in <= modes[i];
         @(posedge core_clk_in);
         #1;
         check("mode", {30'h0, mode_request_in}, {30'h0, op_mode_out});
      end
      @(posedge core_clk_in);
      mode_request_in <= charge_pkg::MODE_CHARGE;
      sense_in.below_short <= 1'b1;
      $display("test reset and modes done");
      host_model_inst.read_status();
      host_model_inst.set_reset_bit();
      wait_code(charge_pkg::STAT_CHARGING);
      repeat (8) @(posedge core_clk_in);
      #1;
      check("short current", 32'h3, {30'h0, short_on, ibs});
      sense_in.below_short <= 1'b0;
      p = {8'h02, 8'h10, 8'h03, 6'h10, 2'b01};
      host_model_inst.write_params(p, 1'b0);
      #1;
      check("loaded params", p, active_params_out);
      check("short timer mode", 32'h1, {31'h0, stm});
      host_model_inst.write_params(p, 1'b1);
      #1;
      check("kick pulse", 32'h1, {31'h0, kick_out});
      @(posedge core_clk_in);
      #1;
      check("kick cleared", 32'h0, {31'h0, kick_out});
      $display("test host control done");
      duty_request_in <= 10'h000;
      pwm_count();
      check("zero duty", 32'h0, {24'h0, hi});
      duty_request_in <= 10'h1F4;
      pwm_count();
      hi_mid = hi;
      check("half duty on", 32'h1, {31'h0, hi >= 8'h20 && hi <= 8'h21});
      check("async low side", 32'h0, {24'h0, lo});
      check("ramp target", {24'h0, p.input_current_limit}, {24'h0, current_target_out});
      sense_in.low_side_above_sync <= 1'b1;
      pwm_count();
      check("sync low side", 32'h1, {31'h0, lo > 8'h00});
      sense_in.high_side_at_limit <= 1'b1;
      pwm_count();
      check("current limit", 32'h1, {31'h0, hi < hi_mid});
      sense_in.high_side_at_limit <= 1'b0;
      sense_in.thermal_shutdown <= 1'b1;
      pwm_count();
      check("thermal stop", 32'h0, {24'h0, hi | lo});
      sense_in.thermal_shutdown <= 1'b0;
      $display("test switching done");
      sense_in.near_regulation <= 1'b1;
      sense_in.at_termination <= 1'b1;
      host_model_inst.read_status();
      repeat (50) @(posedge core_clk_in);
      #1;
      check("no termination", {30'h0, charge_pkg::STAT_CHARGING}, {30'h0, code});
      p.term_enable = 1'b1;
      host_model_inst.write_params(p, 1'b0);
      wait_code(charge_pkg::STAT_DONE);
      host_model_inst.read_status();
      sense_in.at_termination <= 1'b0;
      sense_in.near_regulation <= 1'b0;
      sense_in.below_recharge <= 1'b1;
      wait_code(charge_pkg::STAT_CHARGING);
      $display("test termination done");
      end_of_test();
   end
endmodule
`default_nettype wire
